// ### bench/rtcpdc_checker.sv
`timescale 1ns/1ps
module rtcpdc_checker (
  // clock and reset
  input wire logic                          mclk,
  input wire logic                          rst_n,
  // time base
  input wire logic                          osc32k,
  // register port
  input wire logic [rtcpdc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [rtcpdc_pkg::DATA_W-1:0] regWrData,
  input wire logic                          regWr,
  input wire logic                          regRd,
  input wire logic [rtcpdc_pkg::DATA_W-1:0] regRdData,
  // test pin and load caps
  input wire logic                          testPinOut,
  input wire logic                          testPinOe,
  input wire logic [rtcpdc_pkg::DATA_W-1:0] loadCapCode,
  // timekeeping pulses
  input wire logic                          hundredthTick,
  input wire logic                          secondTick
);
  import rtcpdc_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // register port
  // ****************************************************************
  // read data must not linger, or a stale byte could be mistaken for a reply
  rd_idle_zero_a: assert property (!regRd |=> regRdData == 8'h00)
    else $error("read data not zero outside a read reply");
  unmapped_read_a: assert property (regRd && regAddr == 5'h1f |=> regRdData == 8'h00)
    else $error("unmapped read returned nonzero data");
  trim_high_bits_a: assert property (
    regRd && regAddr == OFS_DIGITAL_RATE_TRIM |=> regRdData[7:6] == 2'h0)
    else $error("trim register upper bits not zero");

  // ****************************************************************
  // test pin
  // ****************************************************************
  oe_write_a: assert property (
    regWr && regAddr == OFS_TEST_CTRL |=> testPinOe == $past(regWrData[FT_EN_BIT]))
    else $error("test pin enable did not follow control write");
  pin_gated_a: assert property (!testPinOe |-> !testPinOut)
    else $error("test pin toggles while disabled");
  // half period is 32 synchronised oscillator edges, never under 8 clocks
  // a rise caused by enabling the pin may meet a wave that is nearly done
  wave_half_a: assert property (
    $rose(testPinOut) && $past(testPinOe) |-> testPinOut[*8])
    else $error("test wave high phase too short");

  // ****************************************************************
  // load caps and timekeeping
  // ****************************************************************
  cap_range_a: assert property (
    loadCapCode[7] ? loadCapCode[6:0] <= CAP_REM_MAX : loadCapCode[6:0] <= CAP_ADD_MAX)
    else $error("load cap code outside its limits");
  cap_write_a: assert property (
    regWr && regAddr == OFS_LOAD_CAP_TRIM && !regWrData[7] && regWrData[6:0] <= CAP_ADD_MAX
    |=> loadCapCode == $past(regWrData)) else $error("in-range cap write not applied");
  hund_gap_a: assert property (hundredthTick |=> !hundredthTick[*8])
    else $error("hundredth pulses too close together");
  // the second pulse stands beside the hundredth pulse that completes it
  sec_follow_a: assert property (secondTick |-> hundredthTick)
    else $error("second pulse without its hundredth pulse");
endmodule : rtcpdc_checker

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import rtcpdc_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic                          mclk;
  logic                          rst_n;
  logic                          osc32k;
  logic [ADDR_W-1:0]             regAddr;
  logic [DATA_W-1:0]             regWrData;
  logic                          regWr;
  logic                          regRd;
  logic [DATA_W-1:0]             regRdData;
  logic                          testPinOut;
  logic                          testPinOe;
  logic [DATA_W-1:0]             loadCapCode;
  logic                          hundredthTick;
  logic                          secondTick;
  int                            cycle = 0;
  int                            hundCount = 0;
  int                            errCount = 0;
  int                            checkCount = 0;
  int                            t0;
  int                            h0;
  int                            p;
  logic [7:0]                    capIn [7] = '{8'h27, 8'h28, 8'h7f, 8'hc8, 8'hc9, 8'hff, 8'h05};
  logic [7:0]                    capExp [7] = '{8'h27, 8'h27, 8'h27, 8'hc8, 8'hc8, 8'hc8, 8'h05};

  rtcpdc_top u_rtcpdc_top (
    .mclk(mclk), .rst_n(rst_n), .osc32k(osc32k),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .testPinOut(testPinOut), .testPinOe(testPinOe),
    .loadCapCode(loadCapCode), .hundredthTick(hundredthTick), .secondTick(secondTick)
  );

  // ****************************************************************
  // clock, fast time base, counters and watchdog
  // ****************************************************************
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  // oscillator sped up to one rise per two clocks, so a tap is 128 clocks
  always @(posedge mclk) begin
    osc32k <= ~osc32k;
    cycle <= cycle + 1;
    if (hundredthTick === 1'b1) begin
      hundCount <= hundCount + 1;
    end
    if (cycle == 90000) begin
      errCount++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      errCount++;
    end
  endtask : check

  task automatic regWrite(input logic [4:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask : regWrite

  // reply stands only in the cycle after the strobe
  task automatic regRead(input logic [4:0] a, input logic [7:0] exp, input string what);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    check(what, exp, regRdData);
    @(posedge mclk);
  endtask : regRead

  task automatic waitPin(input logic v);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (testPinOut !== v && n < 400);
  endtask : waitPin

  task automatic pinPeriod(output int per);
    int a;
    waitPin(1'b0);
    waitPin(1'b1);
    a = cycle;
    waitPin(1'b0);
    waitPin(1'b1);
    per = cycle - a;
    @(posedge mclk);
  endtask : pinPeriod

  task automatic waitSecond(output int hc);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (secondTick !== 1'b1 && n < 70000);
    // the last hundredth pulse stands beside the second pulse and is
    // counted one edge later
    @(posedge mclk);
    #1;
    hc = hundCount;
    check("second pulse one cycle", 1'b0, secondTick);
    @(posedge mclk);
  endtask : waitSecond

  task automatic testEnd(input string name);
    $display("test %s done", name);
  endtask : testEnd

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    osc32k = 1'b0;
    rst_n = 1'b0;
    regAddr = '0;
    regWrData = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t0 = cycle;
    @(posedge mclk);
    regRead(OFS_DIGITAL_RATE_TRIM, 8'h00, "trim reset");
    regRead(OFS_LOAD_CAP_TRIM, CAP_RESET, "cap reset");
    regRead(OFS_TEST_CTRL, 8'h00, "ctrl reset");
    // the only trim write of the run: positive, two seconds, top bits set
    regWrite(OFS_DIGITAL_RATE_TRIM, 8'he2);
    regRead(OFS_DIGITAL_RATE_TRIM, 8'h22, "trim fields");
    regWrite(5'h1f, 8'h55);
    regRead(5'h1f, 8'h00, "unmapped read");
    regWrite(OFS_SECONDS_STAT, 8'h2a);
    regRead(OFS_SECONDS_STAT, 8'h00, "read-only seconds");
    testEnd("registers");
    // clamp table covers both limits and values past them
    for (int i = 0; i < 7; i++) begin
      regWrite(OFS_LOAD_CAP_TRIM, capIn[i]);
      regRead(OFS_LOAD_CAP_TRIM, capExp[i], "cap readback");
      check("cap code", capExp[i], loadCapCode);
    end
    testEnd("load cap clamp");
    check("pin enable off", 1'b0, testPinOe);
    regWrite(OFS_TEST_CTRL, 8'h01);
    check("pin enable on", 1'b1, testPinOe);
    pinPeriod(p);
    check("test wave period", 128, p);
    testEnd("test pin");
    // the first second always runs at 512; the next one is active
    waitSecond(h0);
    check("hundredths in first second", 100, h0);
    check("first second length", 1'b1, (cycle - t0) inside {[65500:65600]});
    // 46 taps of 511 yield nine pulses, of 512 only eight
    repeat (46 * 128 + 30) @(posedge mclk);
    #1;
    check("hundredths in 46 taps", 9, hundCount - h0);
    @(posedge mclk);
    regRead(OFS_CYCLE_STAT, 8'h80, "cycle status");
    regRead(OFS_HUNDREDTHS_STAT, 8'h09, "hundredths status");
    regRead(OFS_SECONDS_STAT, 8'h01, "seconds status");
    pinPeriod(p);
    check("wave period while trimming", 128, p);
    testEnd("correction");
    tally_and_finish();
  end
endmodule : testbench

bind rtcpdc_top rtcpdc_checker u_rtcpdc_checker (
  .mclk(mclk), .rst_n(rst_n), .osc32k(osc32k),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .testPinOut(testPinOut), .testPinOe(testPinOe),
  .loadCapCode(loadCapCode), .hundredthTick(hundredthTick), .secondTick(secondTick)
);

// ### hw/rtcpdc_div_if.sv
`timescale 1ns/1ps
interface rtcpdc_div_if;
  import rtcpdc_pkg::*;

  logic             tick512;  // one pulse per 512 Hz tap event
  logic [MOD_W-1:0] modulus;  // inputs per 100 outputs, taken at second start
  logic             tick100;  // one pulse per hundredth of a second

  modport ctl (output tick512, output modulus, input tick100);
  modport div (input tick512, input modulus, output tick100);
endinterface : rtcpdc_div_if

// ### hw/rtcpdc_pkg.sv
package rtcpdc_pkg;

  // ****************************************************************
  // register bus geometry
  // ****************************************************************
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_DIGITAL_RATE_TRIM = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_TEST_CTRL         = 5'h0a;
  localparam logic [ADDR_W-1:0] OFS_SECONDS_STAT      = 5'h0b;
  localparam logic [ADDR_W-1:0] OFS_CYCLE_STAT        = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_HUNDREDTHS_STAT   = 5'h0d;
  localparam logic [ADDR_W-1:0] OFS_LOAD_CAP_TRIM     = 5'h12;

  // ****************************************************************
  // field layouts and reset values
  // ****************************************************************
  localparam int unsigned TRIM_MAG_LSB  = 0;
  localparam int unsigned TRIM_MAG_W    = 5;
  localparam int unsigned TRIM_SIGN_BIT = 5;
  localparam int unsigned FT_EN_BIT     = 0;
  localparam int unsigned CAP_SIGN_BIT  = 7;
  localparam int unsigned CAP_MAG_W     = 7;
  localparam int unsigned CYC_ACT_BIT   = 7;
  localparam logic [5:0]        TRIM_RESET = 6'h00;
  localparam logic [DATA_W-1:0] CAP_RESET  = 8'h00;
  localparam logic              FT_RESET   = 1'b0;

  // load capacitance limits, magnitude in quarter picofarads
  localparam logic [CAP_MAG_W-1:0] CAP_ADD_MAX = 7'h27;
  localparam logic [CAP_MAG_W-1:0] CAP_REM_MAX = 7'h48;

  // ****************************************************************
  // divider chain counts
  // ****************************************************************
  localparam int unsigned OSC_TAP_DIV  = 64;
  localparam int unsigned PRESC_W      = 6;
  localparam int unsigned MOD_W        = 10;
  localparam logic [MOD_W-1:0] MOD_NORMAL = 10'h200;
  localparam logic [MOD_W-1:0] MOD_FAST   = 10'h1ff;
  localparam logic [MOD_W-1:0] MOD_SLOW   = 10'h201;
  localparam logic [MOD_W-1:0] PULSES_PER_SEC = 10'h064;
  localparam int unsigned HUND_MAX = 99;
  localparam int unsigned SEC_MAX  = 59;
  localparam int unsigned MIN_MAX  = 15;

endpackage : rtcpdc_pkg

// ### hw/rtcpdc_rate_divider.sv
`timescale 1ns/1ps
module rtcpdc_rate_divider (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // tap in, hundredths out
  rtcpdc_div_if.div dv
);
  import rtcpdc_pkg::*;

  logic [MOD_W-1:0] acc_r;
  logic [MOD_W-1:0] acc_nxt;
  logic             pulse_r;
  logic             pulse_nxt;
  logic [MOD_W:0]   sum;

  // fractional accumulator: 100 outputs per modulus inputs, with the
  // accumulator back at zero exactly when the hundredth pulse goes out,
  // so a modulus change at a second boundary never leaves a remainder
  always_comb begin
    sum       = {1'b0, acc_r} + {1'b0, PULSES_PER_SEC};
    acc_nxt   = acc_r;
    pulse_nxt = 1'b0;
    if (dv.tick512) begin
      if (sum >= {1'b0, dv.modulus}) begin
        acc_nxt   = MOD_W'(sum - {1'b0, dv.modulus});
        pulse_nxt = 1'b1;
      end else begin
        acc_nxt   = sum[MOD_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r   <= '0;
      pulse_r <= 1'b0;
    end else begin
      acc_r   <= acc_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign dv.tick100 = pulse_r;

endmodule : rtcpdc_rate_divider

// ### hw/rtcpdc_top.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module rtcpdc_top (
  // clock and reset
  input  wire logic                             mclk,
  input  wire logic                             rst_n,
  // oscillator time base, asynchronous square wave
  input  wire logic                             osc32k,
  // register port
  input  wire logic [rtcpdc_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic [rtcpdc_pkg::DATA_W-1:0]    regWrData,
  input  wire logic                             regWr,
  input  wire logic                             regRd,
  output logic      [rtcpdc_pkg::DATA_W-1:0]    regRdData,
  // shared test pin
  output logic                                  testPinOut,
  output logic                                  testPinOe,
  // load capacitor selection for both crystal pins
  output logic      [rtcpdc_pkg::DATA_W-1:0]    loadCapCode,
  // timekeeping pulses for the downstream counters
  output logic                                  hundredthTick,
  output logic                                  secondTick
);
  import rtcpdc_pkg::*;

  // ****************************************************************
  // oscillator synchroniser and edge detect
  // ****************************************************************
  logic oscMeta_r;
  logic oscMeta_nxt;
  logic oscSync_r;
  logic oscSync_nxt;
  logic oscLast_r;
  logic oscLast_nxt;
  logic oscEdge;

  // the oscillator is unrelated to mclk, so it passes two flip-flops
  // before anything reads it; the few clocks of latency are harmless
  // because every later stage counts edges, not time
  // the edge detector reads only the second stage and its delayed copy
  always_comb begin
    oscMeta_nxt = osc32k;
    oscSync_nxt = oscMeta_r;
    oscLast_nxt = oscSync_r;
    oscEdge     = oscSync_r && !oscLast_r;
  end

  // synchroniser stages and the delayed copy for edge detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oscMeta_r <= 1'b0;
      oscSync_r <= 1'b0;
      oscLast_r <= 1'b0;
    end else begin
      oscMeta_r <= oscMeta_nxt;
      oscSync_r <= oscSync_nxt;
      oscLast_r <= oscLast_nxt;
    end
  end

  // ****************************************************************
  // 512 Hz tap and test square wave
  // ****************************************************************
  // the test wave is taken here on purpose: the trim only reshapes the
  // hundredths stage downstream, so a frequency counter on the pin sees
  // the raw oscillator error and can measure it while a trim is active
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(OSC_TAP_DIV - 1);

  logic [PRESC_W-1:0] presc_r;
  logic [PRESC_W-1:0] presc_nxt;
  logic               tap512;
  logic               sqWave_r;
  logic               sqWave_nxt;

  // divide the oscillator by 64; the tap fires once per prescaler wrap
  // and the square wave is the prescaler msb, before any correction
  always_comb begin
    presc_nxt  = presc_r;
    tap512     = oscEdge && (presc_r == PRESC_LAST);
    if (oscEdge) begin
      presc_nxt = presc_r + 1'b1;
    end
    sqWave_nxt = presc_r[PRESC_W-1];
  end

  // prescaler and registered square wave
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      presc_r  <= '0;
      sqWave_r <= 1'b0;
    end else begin
      presc_r  <= presc_nxt;
      sqWave_r <= sqWave_nxt;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // register file and the fields decoded from it
  logic [5:0]        trim_r;
  logic [5:0]        trim_nxt;
  logic [DATA_W-1:0] capTrim_r;
  logic [DATA_W-1:0] capTrim_nxt;
  logic              ftEnable_r;
  logic              ftEnable_nxt;
  logic [DATA_W-1:0] rdData_r;
  logic [DATA_W-1:0] rdData_nxt;
  logic [CAP_MAG_W-1:0] capMag;
  logic                 capNeg;
  logic [4:0]        trimMagnitude;
  logic              trimSign;

  // counter views for status reads and scheduling
  logic [6:0] hundCount;
  logic [5:0] secCount;
  logic [3:0] minCount;
  logic       cycleActive_r;

  // trim fields; a mid-cycle change is taken at the next second
  // boundary, but changing it faster than the cycle skews the average,
  // and a change never disturbs the second already running
  always_comb begin
    trimMagnitude = trim_r[TRIM_MAG_LSB +: TRIM_MAG_W];
    trimSign      = trim_r[TRIM_SIGN_BIT];
    capNeg        = regWrData[CAP_SIGN_BIT];
    capMag        = regWrData[CAP_MAG_W-1:0];
  end

  // a read right after a write to the same register already returns
  // the new value, since the write lands on the strobe's own edge
  // writes store the value; reads answer in the next cycle only
  always_comb begin
    trim_nxt     = trim_r;
    capTrim_nxt  = capTrim_r;
    ftEnable_nxt = ftEnable_r;
    rdData_nxt   = '0;
    if (regWr) begin
      case (regAddr)
        OFS_DIGITAL_RATE_TRIM: begin
          trim_nxt = regWrData[5:0];
        end
        OFS_LOAD_CAP_TRIM: begin
          // the sign selects removal (fast) or addition (slow) of load
          // capacitance; the two limits differ, so each has its own clamp
          // out-of-range requests saturate at the nearest limit
          if (capNeg && (capMag > CAP_REM_MAX)) begin
            capTrim_nxt = {1'b1, CAP_REM_MAX};
          end else if (!capNeg && (capMag > CAP_ADD_MAX)) begin
            capTrim_nxt = {1'b0, CAP_ADD_MAX};
          end else begin
            capTrim_nxt = regWrData;
          end
        end
        OFS_TEST_CTRL: begin
          ftEnable_nxt = regWrData[FT_EN_BIT];
        end
        default: begin
          trim_nxt = trim_r;
        end
      endcase
    end
    // status views let software see the correction phase
    if (regRd) begin
      case (regAddr)
        OFS_DIGITAL_RATE_TRIM: rdData_nxt = {2'b00, trim_r};
        OFS_LOAD_CAP_TRIM:     rdData_nxt = capTrim_r;
        OFS_TEST_CTRL:         rdData_nxt = {7'h00, ftEnable_r};
        OFS_SECONDS_STAT:      rdData_nxt = {2'b00, secCount};
        OFS_CYCLE_STAT:        rdData_nxt = {cycleActive_r, 3'b000, minCount};
        OFS_HUNDREDTHS_STAT:   rdData_nxt = {1'b0, hundCount};
        default:               rdData_nxt = '0;  // unmapped reads as zero
      endcase
    end
  end

  // register file and read reply
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trim_r     <= TRIM_RESET;
      capTrim_r  <= CAP_RESET;
      ftEnable_r <= FT_RESET;
      rdData_r   <= '0;
    end else begin
      trim_r     <= trim_nxt;
      capTrim_r  <= capTrim_nxt;
      ftEnable_r <= ftEnable_nxt;
      rdData_r   <= rdData_nxt;
    end
  end

  // ****************************************************************
  // hundredths divider
  // ****************************************************************
  // the modulus is held in a register and changes only at a second
  // boundary, when the accumulator stands at zero, so no second is
  // ever split between two ratios
  rtcpdc_div_if divBus ();

  logic [MOD_W-1:0] modulus_r;
  logic [MOD_W-1:0] modulus_nxt;

  // the divider sees the raw tap and the registered modulus
  assign divBus.tick512 = tap512;
  assign divBus.modulus = modulus_r;

  rtcpdc_rate_divider u_divider (
    .mclk  (mclk),
    .rst_n (rst_n),
    .dv    (divBus.div)
  );

  // ****************************************************************
  // fraction, seconds and correction-cycle minute counters
  // ****************************************************************
  // wrap strobes are combinational and last exactly one clock
  logic hundWrap;
  logic secWrap;

  // hundredths pulses drive the fraction counter
  rtcpdc_wrap_counter #(.WIDTH(7), .MAX(HUND_MAX)) u_hund (
    .mclk  (mclk),
    .rst_n (rst_n),
    .inc   (divBus.tick100),
    .count (hundCount),
    .wrap  (hundWrap)
  );

  // seconds advance on each fraction wrap
  rtcpdc_wrap_counter #(.WIDTH(6), .MAX(SEC_MAX)) u_sec (
    .mclk  (mclk),
    .rst_n (rst_n),
    .inc   (hundWrap),
    .count (secCount),
    .wrap  (secWrap)
  );

  // free-running; positive mode looks at the low three bits only,
  // so one counter serves both the 8- and 16-minute cycle
  rtcpdc_wrap_counter #(.WIDTH(4), .MAX(MIN_MAX)) u_min (
    .mclk  (mclk),
    .rst_n (rst_n),
    .inc   (secWrap),
    .count (minCount),
    .wrap  ()
  );

  // ****************************************************************
  // correction scheduling
  // ****************************************************************
  // boundary look-ahead and registered strobes
  logic [5:0] secNext;
  logic [3:0] minNext;
  logic       cycleStart;
  logic       activeNext;
  logic       secInWindow;
  logic       cycleActive_nxt;
  logic       secTick_r;
  logic       secTick_nxt;
  logic       hundTick_r;
  logic       hundTick_nxt;

  // limitation: the minute counter starts at zero on reset and is not
  // tied to the calendar minute, so the cycle phase is arbitrary; only
  // the average correction over a whole cycle is meaningful
  // the modulus for the coming second is chosen from the counters as
  // they will stand after this boundary, while the accumulator is zero
  always_comb begin
    secNext    = secWrap ? 6'h00 : secCount + 1'b1;
    minNext    = secWrap ? minCount + 1'b1 : minCount;
    if (trimSign) begin
      cycleStart = (minNext[2:0] == 3'b000);
    end else begin
      cycleStart = (minNext == 4'h0);
    end
    // about 4.068 or 2.034 ppm per step averaged over the cycle
    // a second is active when it falls in the first N seconds of the
    // cycle-start minute; N of zero never matches, whatever the sign
    secInWindow = ({1'b0, secNext} < {2'b00, trimMagnitude});
    activeNext  = (trimMagnitude != 5'h00) && cycleStart && secInWindow;
    modulus_nxt     = modulus_r;
    cycleActive_nxt = cycleActive_r;
    if (hundWrap) begin
      cycleActive_nxt = activeNext;
      if (!activeNext) begin
        modulus_nxt = MOD_NORMAL;
      end else if (trimSign) begin
        modulus_nxt = MOD_FAST;
      end else begin
        modulus_nxt = MOD_SLOW;
      end
    end
    secTick_nxt  = hundWrap;
    hundTick_nxt = divBus.tick100;
  end

  // modulus, phase flag and output strobes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      modulus_r     <= MOD_NORMAL;
      cycleActive_r <= 1'b0;
      secTick_r     <= 1'b0;
      hundTick_r    <= 1'b0;
    end else begin
      modulus_r     <= modulus_nxt;
      cycleActive_r <= cycleActive_nxt;
      secTick_r     <= secTick_nxt;
      hundTick_r    <= hundTick_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // the ticks are registered copies of the internal strobes, one clock
  // late; the second pulse stands beside the hundredth pulse that ends it
  // the pin is released when the test output is off so the shared
  // function can use it; enable and level switch on the same edge
  assign testPinOut    = sqWave_r & ftEnable_r;
  assign testPinOe     = ftEnable_r;
  assign loadCapCode   = capTrim_r;
  assign regRdData     = rdData_r;
  assign hundredthTick = hundTick_r;
  assign secondTick    = secTick_r;

endmodule : rtcpdc_top

// ### hw/rtcpdc_wrap_counter.sv
`timescale 1ns/1ps
module rtcpdc_wrap_counter #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned MAX   = 99
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // counting
  input  wire logic             inc,
  output logic [WIDTH-1:0]      count,
  output logic                  wrap
);

  localparam logic [WIDTH-1:0] LAST = WIDTH'(MAX);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  // advance on each increment, fold back to zero after the last value
  always_comb begin
    wrap      = inc && (count_r == LAST);
    count_nxt = count_r;
    if (inc) begin
      count_nxt = wrap ? '0 : count_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

endmodule : rtcpdc_wrap_counter
